// ==== hw/fcsg_pkg.sv ====
// Constants, types and helpers shared by the free-run stop and start guard block
package fcsg_pkg;

   // Clock and time base
   localparam int CLK_FREQ_MHZ = 10;
   localparam int MS_TIME_US = 1000;
   localparam int MS_TICK_CYC = CLK_FREQ_MHZ * MS_TIME_US;
   localparam int ACCEL_STEP_TIME_US = 10;
   localparam int ACCEL_STEP_CYC = CLK_FREQ_MHZ * ACCEL_STEP_TIME_US;
   localparam int POWERUP_WINDOW_S = 2;
   localparam logic [10:0] POWERUP_WINDOW_MS = 11'(POWERUP_WINDOW_S * MS_TIME_US);
   localparam logic [16:0] WAIT_UNIT_MS = 17'h00064;

   // Terminal function codes and setting values
   localparam logic [7:0] FUNC_FREE_RUN = 8'h0b;
   localparam logic [7:0] FUNC_START_GUARD = 8'h0d;
   localparam logic [1:0] SRC_TERMINAL = 2'h1;
   localparam logic [1:0] SRC_KEYPAD = 2'h2;
   localparam logic [1:0] SRC_MODBUS = 2'h3;
   localparam logic MODE_ZERO = 1'h0;
   localparam logic MODE_MATCH = 1'h1;
   localparam logic [1:0] FSEL_SHUTOFF = 2'h0;
   localparam logic [1:0] FSEL_MAX = 2'h1;
   localparam logic [1:0] FSEL_NEW = 2'h2;

   // Setting ranges: wait in 0.1 s, freq in 0.01 Hz, scan time in ms, current in %
   localparam logic [31:0] WAIT_MIN = 32'h00000003;
   localparam logic [31:0] WAIT_MAX = 32'h000003e8;
   localparam logic [31:0] FREQ_MAX = 32'h00009c40;
   localparam logic [31:0] SCAN_MIN = 32'h00000064;
   localparam logic [31:0] SCAN_MAX = 32'h002dc6c0;
   localparam logic [31:0] ILIM_MIN = 32'h00000014;
   localparam logic [31:0] ILIM_MAX = 32'h000000c8;
   localparam logic [23:0] PERCENT_SCALE = 24'h000064;

   // Register byte offsets
   localparam logic [7:0] OFF_TERM_LO = 8'h00;
   localparam logic [7:0] OFF_TERM_HI = 8'h04;
   localparam logic [7:0] OFF_RUN_CFG = 8'h08;
   localparam logic [7:0] OFF_RETRY_WAIT = 8'h0c;
   localparam logic [7:0] OFF_FREQ_THRESH = 8'h10;
   localparam logic [7:0] OFF_SCAN_TIME = 8'h14;
   localparam logic [7:0] OFF_SCAN_ILIM = 8'h18;
   localparam logic [7:0] OFF_SET_FREQ = 8'h1c;
   localparam logic [7:0] OFF_MAX_FREQ = 8'h20;
   localparam logic [7:0] OFF_STATUS = 8'h24;
   localparam logic [7:0] OFF_INT_STAT = 8'h28;
   localparam logic [7:0] OFF_INT_MASK = 8'h2c;

   // Field positions
   localparam int CFG_SRC_LSB = 0;
   localparam int CFG_MODE_BIT = 8;
   localparam int CFG_FSEL_LSB = 16;
   localparam int STS_STATE_LSB = 0;
   localparam int STS_EN_BIT = 8;
   localparam int STS_TRIP_BIT = 9;
   localparam int STS_FRS_BIT = 10;
   localparam int STS_FREQ_LSB = 16;
   localparam int IRQ_TRIP = 0;
   localparam int IRQ_COAST = 1;
   localparam int IRQ_RESTART = 2;
   localparam int IRQ_MATCH = 3;

   // Reset values
   localparam logic [1:0] RST_SRC = 2'h1;
   localparam logic [9:0] RST_WAIT = 10'h00a;
   localparam logic [21:0] RST_SCAN = 22'h0003e8;
   localparam logic [7:0] RST_ILIM = 8'h64;
   localparam logic [15:0] RST_MAX_FREQ = 16'h1770;

   typedef enum logic [2:0] {ST_STOP, ST_RUN, ST_ACCEL, ST_COAST, ST_WAIT, ST_SCAN} fcsg_mode_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } fcsg_bus_req_type;

   typedef struct packed {
      fcsg_mode_type st;
      logic [31:0] trm_lo;
      logic [7:0] trm_hi;
      logic [1:0] src;
      logic mode;
      logic [1:0] fsel;
      logic [9:0] wait_set;
      logic [15:0] thr;
      logic [21:0] scan;
      logic [7:0] ilim;
      logic [15:0] setf;
      logic [15:0] maxf;
      logic [3:0] istat;
      logic [3:0] imask;
      logic [31:0] rdata;
      logic [15:0] freq;
      logic [15:0] tgt;
      logic [15:0] stored;
      logic [16:0] wait_ms;
      logic [10:0] pwr_ms;
      logic pwr_done;
      logic trip;
      logic need_new;
      logic rs_prev;
      logic free_run_input;
   } fcsg_state_type;

   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } fcsg_div_state_type;

   typedef struct packed {
      logic [22:0] acc;
      logic step;
   } fcsg_pace_state_type;

   function automatic logic [31:0] fcsg_clamp(input logic [31:0] v, input logic [31:0] lo,
                                              input logic [31:0] hi);
      if (v < lo)
      begin
         return lo;
      end
      else if (v > hi)
      begin
         return hi;
      end
      return v;
   endfunction : fcsg_clamp

endpackage : fcsg_pkg

// ==== hw/fcsg_tick_div.sv ====
// Clock divider giving a one-cycle enable pulse every PERIOD cycles
`timescale 1ns/1ns
`default_nettype none
module fcsg_tick_div #(
   parameter int PERIOD = 100
) (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   output logic tick_out
);
   fcsg_pkg::fcsg_div_state_type s_q;
   fcsg_pkg::fcsg_div_state_type s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.count >= 32'(PERIOD - 1))
      begin
         s_d.count = '0;
         s_d.tick = 1'b1;
      end
      else
      begin
         s_d.count = s_q.count + 32'h00000001;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.tick;
endmodule : fcsg_tick_div
`default_nettype wire

// ==== hw/fcsg_scan_pace.sv ====
// Paces the frequency fall during a scan: full scale over the scan time
`timescale 1ns/1ns
`default_nettype none
module fcsg_scan_pace (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire logic en_in,
   input wire logic ms_tick_in,
   input wire logic [15:0] max_freq_in,
   input wire logic [21:0] scan_time_in,
   output logic step_out
);
   fcsg_pkg::fcsg_pace_state_type s_q;
   fcsg_pkg::fcsg_pace_state_type s_d;

   // At most one step per cycle; the minimum scan time keeps the backlog bounded
   always_comb
   begin
      s_d = s_q;
      s_d.step = 1'b0;
      if (!en_in)
      begin
         s_d.acc = '0;
      end
      else if (ms_tick_in)
      begin
         s_d.acc = s_q.acc + {7'h00, max_freq_in};
      end
      else if (s_q.acc >= {1'b0, scan_time_in})
      begin
         s_d.acc = s_q.acc - {1'b0, scan_time_in};
         s_d.step = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign step_out = s_q.step;
endmodule : fcsg_scan_pace
`default_nettype wire

// ==== hw/fcsg_core.sv ====
// Free-run stop, restart and unattended start guard control with register port
// Operation
// - Free-run input exists only via terminal code 11
// - Free-run asserted keeps motor output shut off
// - Release restarts after retry wait, 0.3-100 s
// - Keypad source: no auto restart, new command
// - Mode 00 zero start, 01 frequency matching
// - Below threshold, matching restarts from zero
// - Zero mode starts 0 Hz, ignores wait
// - Start frequency: shutoff, maximum, or newly set
// - Scan lowers frequency, current held at limit
// - Matched: accelerate back to shutoff frequency
// - Code 13: run at power-up trips
// - Trip cleared by reset or run removal
// - Cleared with run held: run immediately
// - Run asserted after power-up runs normally
// - Terminal/Modbus run within two seconds trips
// - Panel run/stop keys bypass start guard
// - Reset during wait clears stored frequency
`timescale 1ns/1ns
`default_nettype none
module fcsg_core #(
   parameter int MS_TICK_CYC = fcsg_pkg::MS_TICK_CYC
) (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire fcsg_pkg::fcsg_bus_req_type bus_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [4:0] term_in,
   input wire logic run_term_in,
   input wire logic keypad_run_in,
   input wire logic modbus_run_in,
   input wire logic trip_reset_input_in,
   input wire logic [15:0] motor_freq_in,
   input wire logic [15:0] current_in,
   input wire logic [15:0] rated_current_in,
   output logic out_enable_out,
   output logic [15:0] freq_out,
   output logic unattended_start_error_out,
   output logic free_run_active_out,
   output logic irq_out
);
   fcsg_pkg::fcsg_state_type s_q;
   fcsg_pkg::fcsg_state_type s_d;

   logic ms_tick;
   logic accel_tick;
   logic scan_step;
   logic scan_en;
   logic over_limit;
   logic [23:0] cur_x100;
   logic [23:0] cur_lim;
   logic [16:0] wait_total;

   function automatic logic [7:0] term_func(input logic [39:0] codes, input int idx);
      return codes[idx * 8 +: 8];
   endfunction : term_func

   fcsg_tick_div #(
      .PERIOD(MS_TICK_CYC)
   ) u_ms_div (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .tick_out(ms_tick)
   );

   fcsg_tick_div #(
      .PERIOD(fcsg_pkg::ACCEL_STEP_CYC)
   ) u_accel_div (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .tick_out(accel_tick)
   );

   // Current compared in percent of rated to avoid a divider
   assign cur_x100 = 24'(current_in) * fcsg_pkg::PERCENT_SCALE;
   assign cur_lim = 24'(rated_current_in) * 24'(s_q.ilim);
   assign over_limit = cur_x100 > cur_lim;
   // During a scan the frequency is frozen while current is above the limit
   assign scan_en = (s_q.st == fcsg_pkg::ST_SCAN) && !over_limit;
   assign wait_total = {7'h00, s_q.wait_set} * fcsg_pkg::WAIT_UNIT_MS;

   fcsg_scan_pace u_pace (
      .core_clk_in(core_clk_in),
      .nrst_in(nrst_in),
      .en_in(scan_en),
      .ms_tick_in(ms_tick),
      .max_freq_in(s_q.maxf),
      .scan_time_in(s_q.scan),
      .step_out(scan_step)
   );

   logic frs_in;
   logic guard_en;
   logic guard_block;
   logic run_cmd;
   logic rs_edge;
   logic start_ok;
   logic [3:0] ev;
   logic [3:0] w1c;
   logic [15:0] restart_freq;

   always_comb
   begin
      s_d = s_q;
      frs_in = 1'b0;
      guard_en = 1'b0;
      ev = '0;
      w1c = '0;
      restart_freq = s_q.stored;
      for (int i = 0; i < 5; i++)
      begin
         if (term_func({s_q.trm_hi, s_q.trm_lo}, i) == fcsg_pkg::FUNC_FREE_RUN && term_in[i])
         begin
            frs_in = 1'b1;
         end
         if (term_func({s_q.trm_hi, s_q.trm_lo}, i) == fcsg_pkg::FUNC_START_GUARD)
         begin
            guard_en = 1'b1;
         end
      end
      s_d.free_run_input = frs_in;

      if (s_q.src == fcsg_pkg::SRC_TERMINAL)
      begin
         run_cmd = run_term_in;
      end
      else if (s_q.src == fcsg_pkg::SRC_KEYPAD)
      begin
         run_cmd = keypad_run_in;
      end
      else if (s_q.src == fcsg_pkg::SRC_MODBUS)
      begin
         run_cmd = modbus_run_in;
      end
      else
      begin
         run_cmd = 1'b0;
      end
      rs_edge = trip_reset_input_in && !s_q.rs_prev;
      s_d.rs_prev = trip_reset_input_in;

      // Power-up window; the guard ignores the panel keys
      if (!s_q.pwr_done && ms_tick)
      begin
         if (s_q.pwr_ms == fcsg_pkg::POWERUP_WINDOW_MS - 11'h001)
         begin
            s_d.pwr_done = 1'b1;
         end
         else
         begin
            s_d.pwr_ms = s_q.pwr_ms + 11'h001;
         end
      end
      guard_block = guard_en && !s_q.pwr_done && s_q.src != fcsg_pkg::SRC_KEYPAD;
      if (guard_block && !s_q.trip && run_cmd)
      begin
         s_d.trip = 1'b1;
         ev[fcsg_pkg::IRQ_TRIP] = 1'b1;
      end
      else if (s_q.trip && (rs_edge || !run_cmd))
      begin
         // Closing the window stops a re-trip when run stays on
         s_d.trip = 1'b0;
         s_d.pwr_done = 1'b1;
      end
      start_ok = run_cmd && !s_q.trip && !guard_block && !s_q.need_new && !frs_in;

      // A trip raised while running must cut the output at once
      if (s_q.trip || s_d.trip)
      begin
         s_d.st = fcsg_pkg::ST_STOP;
         s_d.freq = '0;
      end
      else
      begin
         case (s_q.st)
            fcsg_pkg::ST_STOP:
            begin
               s_d.freq = '0;
               if (!run_cmd)
               begin
                  s_d.need_new = 1'b0;
               end
               if (start_ok)
               begin
                  s_d.st = fcsg_pkg::ST_ACCEL;
                  s_d.tgt = s_q.setf;
               end
            end
            fcsg_pkg::ST_RUN, fcsg_pkg::ST_ACCEL, fcsg_pkg::ST_SCAN:
            begin
               if (frs_in)
               begin
                  s_d.st = fcsg_pkg::ST_COAST;
                  s_d.stored = s_q.freq;
                  s_d.freq = '0;
                  ev[fcsg_pkg::IRQ_COAST] = 1'b1;
               end
               else if (!run_cmd)
               begin
                  s_d.st = fcsg_pkg::ST_STOP;
                  s_d.freq = '0;
               end
               else if (s_q.st == fcsg_pkg::ST_SCAN)
               begin
                  if (s_q.freq <= motor_freq_in || s_q.freq == 16'h0000)
                  begin
                     s_d.st = fcsg_pkg::ST_ACCEL;
                     s_d.tgt = s_q.stored;
                     ev[fcsg_pkg::IRQ_MATCH] = 1'b1;
                  end
                  else if (scan_step)
                  begin
                     s_d.freq = s_q.freq - 16'h0001;
                  end
               end
               else
               begin
                  if (s_q.st == fcsg_pkg::ST_RUN)
                  begin
                     s_d.tgt = s_q.setf;
                  end
                  else if (s_q.freq == s_q.tgt)
                  begin
                     s_d.st = fcsg_pkg::ST_RUN;
                  end
                  if (accel_tick && s_q.freq < s_q.tgt)
                  begin
                     s_d.freq = s_q.freq + 16'h0001;
                  end
                  else if (accel_tick && s_q.freq > s_q.tgt)
                  begin
                     s_d.freq = s_q.freq - 16'h0001;
                  end
               end
            end
            fcsg_pkg::ST_COAST:
            begin
               s_d.freq = '0;
               if (!frs_in)
               begin
                  if (s_q.src == fcsg_pkg::SRC_KEYPAD)
                  begin
                     s_d.st = fcsg_pkg::ST_STOP;
                     s_d.need_new = 1'b1;
                  end
                  else if (!run_cmd)
                  begin
                     s_d.st = fcsg_pkg::ST_STOP;
                  end
                  else if (s_q.mode == fcsg_pkg::MODE_ZERO)
                  begin
                     s_d.st = fcsg_pkg::ST_ACCEL;
                     s_d.tgt = s_q.setf;
                     ev[fcsg_pkg::IRQ_RESTART] = 1'b1;
                  end
                  else
                  begin
                     s_d.st = fcsg_pkg::ST_WAIT;
                     s_d.wait_ms = '0;
                  end
               end
            end
            fcsg_pkg::ST_WAIT:
            begin
               s_d.freq = '0;
               if (rs_edge)
               begin
                  s_d.stored = '0;
               end
               if (frs_in)
               begin
                  s_d.st = fcsg_pkg::ST_COAST;
               end
               else if (!run_cmd)
               begin
                  s_d.st = fcsg_pkg::ST_STOP;
               end
               else if (ms_tick)
               begin
                  s_d.wait_ms = s_q.wait_ms + 17'h00001;
                  if (s_q.wait_ms >= wait_total - 17'h00001)
                  begin
                     ev[fcsg_pkg::IRQ_RESTART] = 1'b1;
                     if (s_d.stored == 16'h0000 || motor_freq_in < s_q.thr)
                     begin
                        s_d.st = fcsg_pkg::ST_ACCEL;
                        s_d.tgt = s_q.setf;
                     end
                     else
                     begin
                        if (s_q.fsel == fcsg_pkg::FSEL_MAX)
                        begin
                           restart_freq = s_q.maxf;
                        end
                        else if (s_q.fsel == fcsg_pkg::FSEL_NEW)
                        begin
                           restart_freq = s_q.setf;
                        end
                        s_d.st = fcsg_pkg::ST_SCAN;
                        s_d.freq = restart_freq;
                     end
                  end
               end
            end
            default:
            begin
               s_d.st = fcsg_pkg::ST_STOP;
            end
         endcase
      end

      // Register writes; wait, threshold, scan, limit and frequency settings are clamped to their legal range
      if (bus_in.wr)
      begin
         if (bus_in.addr == fcsg_pkg::OFF_TERM_LO)
         begin
            s_d.trm_lo = bus_in.wdata;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_TERM_HI)
         begin
            s_d.trm_hi = bus_in.wdata[7:0];
         end
         else if (bus_in.addr == fcsg_pkg::OFF_RUN_CFG)
         begin
            s_d.src = bus_in.wdata[fcsg_pkg::CFG_SRC_LSB +: 2];
            s_d.mode = bus_in.wdata[fcsg_pkg::CFG_MODE_BIT];
            s_d.fsel = bus_in.wdata[fcsg_pkg::CFG_FSEL_LSB +: 2];
         end
         else if (bus_in.addr == fcsg_pkg::OFF_RETRY_WAIT)
         begin
            s_d.wait_set = 10'(fcsg_pkg::fcsg_clamp(bus_in.wdata, fcsg_pkg::WAIT_MIN,
                                                    fcsg_pkg::WAIT_MAX));
         end
         else if (bus_in.addr == fcsg_pkg::OFF_FREQ_THRESH)
         begin
            s_d.thr = 16'(fcsg_pkg::fcsg_clamp(bus_in.wdata, '0, fcsg_pkg::FREQ_MAX));
         end
         else if (bus_in.addr == fcsg_pkg::OFF_SCAN_TIME)
         begin
            s_d.scan = 22'(fcsg_pkg::fcsg_clamp(bus_in.wdata, fcsg_pkg::SCAN_MIN,
                                                fcsg_pkg::SCAN_MAX));
         end
         else if (bus_in.addr == fcsg_pkg::OFF_SCAN_ILIM)
         begin
            s_d.ilim = 8'(fcsg_pkg::fcsg_clamp(bus_in.wdata, fcsg_pkg::ILIM_MIN,
                                               fcsg_pkg::ILIM_MAX));
         end
         else if (bus_in.addr == fcsg_pkg::OFF_SET_FREQ)
         begin
            s_d.setf = 16'(fcsg_pkg::fcsg_clamp(bus_in.wdata, '0, fcsg_pkg::FREQ_MAX));
         end
         else if (bus_in.addr == fcsg_pkg::OFF_MAX_FREQ)
         begin
            s_d.maxf = 16'(fcsg_pkg::fcsg_clamp(bus_in.wdata, '0, fcsg_pkg::FREQ_MAX));
         end
         else if (bus_in.addr == fcsg_pkg::OFF_INT_STAT)
         begin
            w1c = bus_in.wdata[3:0];
         end
         else if (bus_in.addr == fcsg_pkg::OFF_INT_MASK)
         begin
            s_d.imask = bus_in.wdata[3:0];
         end
      end
      // A new event beats a clear in the same cycle
      s_d.istat = (s_q.istat & ~w1c) | ev;

      s_d.rdata = '0;
      if (bus_in.rd)
      begin
         if (bus_in.addr == fcsg_pkg::OFF_TERM_LO)
         begin
            s_d.rdata = s_q.trm_lo;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_TERM_HI)
         begin
            s_d.rdata[7:0] = s_q.trm_hi;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_RUN_CFG)
         begin
            s_d.rdata[fcsg_pkg::CFG_SRC_LSB +: 2] = s_q.src;
            s_d.rdata[fcsg_pkg::CFG_MODE_BIT] = s_q.mode;
            s_d.rdata[fcsg_pkg::CFG_FSEL_LSB +: 2] = s_q.fsel;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_RETRY_WAIT)
         begin
            s_d.rdata[9:0] = s_q.wait_set;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_FREQ_THRESH)
         begin
            s_d.rdata[15:0] = s_q.thr;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_SCAN_TIME)
         begin
            s_d.rdata[21:0] = s_q.scan;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_SCAN_ILIM)
         begin
            s_d.rdata[7:0] = s_q.ilim;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_SET_FREQ)
         begin
            s_d.rdata[15:0] = s_q.setf;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_MAX_FREQ)
         begin
            s_d.rdata[15:0] = s_q.maxf;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_STATUS)
         begin
            s_d.rdata[fcsg_pkg::STS_STATE_LSB +: 3] = s_q.st;
            s_d.rdata[fcsg_pkg::STS_EN_BIT] = out_enable_out;
            s_d.rdata[fcsg_pkg::STS_TRIP_BIT] = s_q.trip;
            s_d.rdata[fcsg_pkg::STS_FRS_BIT] = s_q.free_run_input;
            s_d.rdata[fcsg_pkg::STS_FREQ_LSB +: 16] = s_q.freq;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_INT_STAT)
         begin
            s_d.rdata[3:0] = s_q.istat;
         end
         else if (bus_in.addr == fcsg_pkg::OFF_INT_MASK)
         begin
            s_d.rdata[3:0] = s_q.imask;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         s_q <= '0;
         s_q.st <= fcsg_pkg::ST_STOP;
         s_q.src <= fcsg_pkg::RST_SRC;
         s_q.wait_set <= fcsg_pkg::RST_WAIT;
         s_q.scan <= fcsg_pkg::RST_SCAN;
         s_q.ilim <= fcsg_pkg::RST_ILIM;
         s_q.maxf <= fcsg_pkg::RST_MAX_FREQ;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Output stage only runs in the driving states
   assign out_enable_out = (s_q.st == fcsg_pkg::ST_RUN) || (s_q.st == fcsg_pkg::ST_ACCEL) ||
                           (s_q.st == fcsg_pkg::ST_SCAN);
   assign freq_out = s_q.freq;
   assign unattended_start_error_out = s_q.trip;
   assign free_run_active_out = s_q.free_run_input;
   assign irq_out = |(s_q.istat & s_q.imask);
   assign reg_rdata_out = s_q.rdata;
endmodule : fcsg_core
`default_nettype wire

// ==== dv/fcsg_cmd_model.sv ====
// Run command source model
`timescale 1ns/1ns
`default_nettype none
module fcsg_cmd_model (
   input wire logic [1:0] src_in,
   input wire logic want_in,
   output logic run_term_out,
   output logic keypad_run_out,
   output logic modbus_run_out
);
   // Only the selected source commands, so no two parties fight
   assign run_term_out = want_in && src_in == fcsg_pkg::SRC_TERMINAL;
   assign keypad_run_out = want_in && src_in == fcsg_pkg::SRC_KEYPAD;
   assign modbus_run_out = want_in && src_in == fcsg_pkg::SRC_MODBUS;
endmodule : fcsg_cmd_model
`default_nettype wire

// ==== dv/fcsg_core_properties.sv ====
// Port checker of the core
`timescale 1ns/1ns
`default_nettype none
module fcsg_core_properties #(
   parameter int MS_TICK_CYC = 10
) (
   input wire logic core_clk_in,
   input wire logic nrst_in,
   input wire fcsg_pkg::fcsg_bus_req_type bus_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic [4:0] term_in,
   input wire logic run_term_in,
   input wire logic modbus_run_in,
   input wire logic trip_reset_input_in,
   input wire logic out_enable_out,
   input wire logic unattended_start_error_out,
   input wire logic free_run_active_out
);
   logic [31:0] up_q;
   always_ff @(posedge core_clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         up_q <= 32'h0;
      end
      else
      begin
         up_q <= up_q + 32'h1;
      end
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence cleared_run;
      $fell(unattended_start_error_out) && run_term_in;
   endsequence
   a_rdata_idle: assert property (!$past(bus_in.rd) |-> reg_rdata_out == 32'h0)
      else $error("read data outside read cycle");
   a_unmapped_zero: assert property ($past(bus_in.rd) && $past(bus_in.addr) > 8'h2c
      |-> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
   a_trip_no_out: assert property (unattended_start_error_out |-> !out_enable_out)
      else $error("output on while tripped");
   a_frs_cut: assert property (free_run_active_out |-> !out_enable_out)
      else $error("output on during free run");
   a_frs_input: assert property (free_run_active_out |-> $past(term_in) != 5'h0)
      else $error("free run without input");
   a_clear_run: assert property (cleared_run |-> ##[0:3] out_enable_out)
      else $error("no run after trip clear");
   a_trip_window: assert property ($rose(unattended_start_error_out)
      |-> up_q <= 2000 * MS_TICK_CYC + 8) else $error("trip after window");
   a_trip_cause: assert property ($fell(unattended_start_error_out)
      |-> $past(trip_reset_input_in) || $past(trip_reset_input_in, 2)
      || !$past(run_term_in) && !$past(modbus_run_in)) else $error("trip cleared alone");
endmodule : fcsg_core_properties
bind fcsg_core fcsg_core_properties #(.MS_TICK_CYC(MS_TICK_CYC)) i_fcsg_core_properties (
   .core_clk_in, .nrst_in, .bus_in, .reg_rdata_out, .term_in, .run_term_in, .modbus_run_in,
   .trip_reset_input_in, .out_enable_out, .unattended_start_error_out, .free_run_active_out);
`default_nettype wire

// ==== dv/fcsg_core_tb.sv ====
// Bench of the core
`timescale 1ns/1ns
`default_nettype none
module fcsg_core_tb;
   logic core_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   fcsg_pkg::fcsg_bus_req_type bus = '0;
   logic [4:0] term = 5'h00;
   logic [1:0] src = fcsg_pkg::SRC_TERMINAL;
   logic want = 1'b0;
   logic rs = 1'b0;
   logic rt, rk, rm, oen, err, free_run_input, irq;
   logic [31:0] rdata;
   logic [15:0] freq;
   int mismatches = 0;
   int checks = 0;
   always #50 core_clk_in = ~core_clk_in;
   fcsg_cmd_model i_fcsg_cmd_model (.src_in(src), .want_in(want), .run_term_out(rt),
      .keypad_run_out(rk), .modbus_run_out(rm));
   fcsg_core #(.MS_TICK_CYC(10)) i_fcsg_core (.core_clk_in, .nrst_in, .bus_in(bus),
      .reg_rdata_out(rdata), .term_in(term), .run_term_in(rt), .keypad_run_in(rk),
      .modbus_run_in(rm), .trip_reset_input_in(rs), .motor_freq_in(16'h0000),
      .current_in(16'h0000), .rated_current_in(16'h0064), .out_enable_out(oen),
      .freq_out(freq), .unattended_start_error_out(err), .free_run_active_out(free_run_input),
      .irq_out(irq));
   task automatic conclude;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
      begin
         $display("TB: PASS");
      end
      else
      begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_in);
      bus <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk_in);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_in);
      bus <= '0;
      #1 chk(rdata, exp);
   endtask : rd
   task automatic wait_oen(input logic exp, input int n);
      #1;
      for (int i = 0; i < n && oen !== exp; i++)
      begin
         @(posedge core_clk_in);
         #1;
      end
      chk(oen, exp);
      if (oen !== exp)
      begin
         conclude();
      end
   endtask : wait_oen
   // Frees the motor, then releases after a while
   task automatic coast(input int n);
      @(posedge core_clk_in);
      term <= 5'h02;
      wait_oen(1'b0, 4);
      repeat (n) @(posedge core_clk_in);
      term <= 5'h00;
   endtask : coast
   initial
   begin
      repeat (2) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      wr(fcsg_pkg::OFF_TERM_LO, 32'h0000000d);
      want <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      #1 chk(err, 1'b1);
      chk(oen, 1'b0);
      @(posedge core_clk_in);
      rs <= 1'b1;
      @(posedge core_clk_in);
      rs <= 1'b0;
      wait_oen(1'b1, 4);
      chk(err, 1'b0);
      wr(fcsg_pkg::OFF_TERM_LO, 32'h00000b0d);
      wr(fcsg_pkg::OFF_INT_MASK, 32'h00000002);
      coast(5);
      #1 chk(irq, 1'b1);
      wr(fcsg_pkg::OFF_INT_STAT, 32'h00000002);
      @(posedge core_clk_in);
      #1 chk(irq, 1'b0);
      wait_oen(1'b1, 3);
      chk(freq, 32'h0);
      wr(fcsg_pkg::OFF_RETRY_WAIT, 32'h00000001);
      rd(fcsg_pkg::OFF_RETRY_WAIT, 32'h00000003);
      wr(fcsg_pkg::OFF_RUN_CFG, 32'h00000101);
      coast(2);
      // Minimum wait of 0.3 s is 3000 cycles with the short tick
      repeat (2900) @(posedge core_clk_in);
      #1 chk(oen, 1'b0);
      wait_oen(1'b1, 200);
      wr(fcsg_pkg::OFF_RUN_CFG, 32'h00000002);
      src <= fcsg_pkg::SRC_KEYPAD;
      wait_oen(1'b1, 4);
      coast(2);
      repeat (50) @(posedge core_clk_in);
      #1 chk(oen, 1'b0);
      @(posedge core_clk_in);
      want <= 1'b0;
      @(posedge core_clk_in);
      want <= 1'b1;
      wait_oen(1'b1, 4);
      rd(8'h40, 32'h00000000);
      conclude();
   end
endmodule : fcsg_core_tb
`default_nettype wire
